// file: rtl/vbmc_pkg.sv
// package for the vector base and mcu control block
// Functional notes
// - reset fetch address is 0x0000 unless boot-reset fuse programmed, then boot address
// - with vector select set, vector address is table address plus boot start
// - boot-reset fuse value 1 means unprogrammed, 0 means programmed
// - vector select is bit 1; clear puts vectors in flash start, set in boot
// - vector select changes only within four cycles after change-enable written one
// - interrupts blocked from change-enable set until after next instruction, else four cycles
// - automatic blocking leaves the cpu global interrupt enable untouched
// - change-enable clears after four cycles or when vector select is written
// - lock bits suppress interrupts while executing from the section without vectors
// - debug-port disable is bit 7; zero enables port if fuse programmed
// - debug-port disable changes only on two equal writes within four cycles
// - brownout-off request: write both bits one, then within four cycles sleep one unlock zero
// - brownout-sleep bit active three cycles after set, cleared three cycles later
// - pull-up global off disables every port pull-up regardless of pin bits
// - control register at data offset 0x55 and io offset 0x35, resets to zero
// - vector entries are two program words apart from the table base
package vbmc_pkg;
	localparam logic [7:0]  VBMC_DATA_OFS   = 8'h55;
	localparam logic [7:0]  VBMC_IO_DELTA   = 8'h20;
	localparam logic [7:0]  VBMC_IO_OFS     = VBMC_DATA_OFS - VBMC_IO_DELTA;
	localparam logic [7:0]  VBMC_RESET_VAL  = 8'h00;
	localparam logic [7:0]  VBMC_RMASK      = 8'hf3;
	localparam int          VBMC_BIT_VECTOR_CHANGE_ENABLE   = 0;
	localparam int          VBMC_BIT_VECTOR_BASE_SELECT  = 1;
	localparam int          VBMC_BIT_PUD    = 4;
	localparam int          VBMC_BIT_BROWNOUT_SLEEP_UNLOCK  = 5;
	localparam int          VBMC_BIT_BROWNOUT_SLEEP_OFF   = 6;
	localparam int          VBMC_BIT_JTD    = 7;
	localparam logic [2:0]  VBMC_WIN_CYC    = 3'h4;
	localparam logic [2:0]  VBMC_BROWNOUT_SLEEP_OFF_DLY   = 3'h3;
	localparam logic [2:0]  VBMC_BROWNOUT_SLEEP_OFF_HOLD  = 3'h3;
	localparam logic [15:0] VBMC_APP_RESET  = 16'h0000;
	localparam logic [15:0] VBMC_VEC_FIRST  = 16'h0002;
	localparam logic [15:0] VBMC_VEC_STRIDE = 16'h0002;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       io_space;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vbmc_bus_t;

	typedef struct packed {
		logic       boot_reset_fuse;
		logic       debug_port_fuse;
		logic       app_lock_bit;
		logic       boot_lock_bit;
		logic [15:0] boot_start;
	} vbmc_fuse_t;
endpackage

// file: rtl/vbmc_top.sv
// vector base select and mcu control register
`timescale 1ns/1ps
module vbmc_top import vbmc_pkg::*; (
	input  wire logic        mclk,          // cpu clock
	input  wire logic        rstn,          // async reset, active low
	input  wire vbmc_bus_t   bus,           // register access from cpu
	input  wire vbmc_fuse_t  fuse,          // fuse and lock bit levels
	input  wire logic        instr_done,    // one pulse per retired instruction
	input  wire logic        exec_in_boot,  // cpu executing from boot section
	input  wire logic [6:0]  vector_num,    // vector index, 0 is reset
	output logic [7:0]       rdata,         // registered read data
	output logic             rvalid,        // read data valid pulse
	output logic [15:0]      reset_addr,    // fetch address after reset
	output logic [15:0]      vector_addr,   // address for vector_num
	output logic             irq_block,     // interrupts held off
	output logic             debug_port_en, // debug port enabled
	output logic             brownout_sleep_active, // sleep may switch brownout off
	output logic             pullup_global_off      // all pull-ups disabled
);
	logic [7:0]  ctrl, next_ctrl;
	logic [2:0]  vector_change_enable_cnt, next_vector_change_enable_cnt;
	logic        blk_seq, next_blk_seq;
	logic        blk_tail, next_blk_tail;
	logic [2:0]  jtd_cnt, next_jtd_cnt;
	logic        jtd_val, next_jtd_val;
	logic [2:0]  brownout_sleep_unlock_cnt, next_brownout_sleep_unlock_cnt;
	logic [2:0]  brownout_sleep_off_cnt, next_brownout_sleep_off_cnt;
	logic        brownout_sleep_off_act, next_brownout_sleep_off_act;
	logic [7:0]  next_rdata;
	logic        next_rvalid;
	logic [15:0] next_reset_addr, next_vector_addr;
	logic        next_irq_block;
	logic        next_debug_port_en;
	logic        next_brownout_sleep_active;
	logic        next_pullup_global_off;
	logic        hit, wr, lock_block;

	// every window and the brownout pulse count cpu clocks, so a slower cpu clock
	// stretches them in time; the block has no other time base.
	// counters run down to zero and stop; a count of one marks the last cycle of a window

	always_comb begin
		hit = (bus.io_space && bus.addr == VBMC_IO_OFS) ||
			(!bus.io_space && bus.addr == VBMC_DATA_OFS);
		wr = bus.wr && hit;
		next_ctrl = ctrl;
		next_vector_change_enable_cnt = (vector_change_enable_cnt != 3'h0) ? vector_change_enable_cnt - 3'h1 : 3'h0;
		next_blk_seq = blk_seq;
		next_blk_tail = 1'b0;
		next_jtd_cnt = (jtd_cnt != 3'h0) ? jtd_cnt - 3'h1 : 3'h0;
		next_jtd_val = jtd_val;
		next_brownout_sleep_unlock_cnt = (brownout_sleep_unlock_cnt != 3'h0) ? brownout_sleep_unlock_cnt - 3'h1 : 3'h0;
		next_brownout_sleep_off_cnt = (brownout_sleep_off_cnt != 3'h0) ? brownout_sleep_off_cnt - 3'h1 : 3'h0;
		next_brownout_sleep_off_act = brownout_sleep_off_act;
		if (vector_change_enable_cnt == 3'h1) begin
			next_ctrl[VBMC_BIT_VECTOR_CHANGE_ENABLE] = 1'b0;
			next_blk_seq = 1'b0;
		end
		if (blk_tail && instr_done) begin
			next_blk_seq = 1'b0;
		end else if (blk_tail) begin
			next_blk_tail = 1'b1;
		end
		// brownout bit: pending for three cycles, then active for three
		if (brownout_sleep_off_cnt == 3'h1) begin
			if (!brownout_sleep_off_act) begin
				next_brownout_sleep_off_act = 1'b1;
				next_brownout_sleep_off_cnt = VBMC_BROWNOUT_SLEEP_OFF_HOLD;
			end else begin
				next_brownout_sleep_off_act = 1'b0;
				next_ctrl[VBMC_BIT_BROWNOUT_SLEEP_OFF] = 1'b0;
			end
		end
		if (brownout_sleep_unlock_cnt == 3'h1) begin
			next_ctrl[VBMC_BIT_BROWNOUT_SLEEP_UNLOCK] = 1'b0;
		end
		if (wr) begin
			next_ctrl[VBMC_BIT_PUD] = bus.wdata[VBMC_BIT_PUD];
			if (bus.wdata[VBMC_BIT_VECTOR_CHANGE_ENABLE]) begin
				next_ctrl[VBMC_BIT_VECTOR_CHANGE_ENABLE] = 1'b1;
				next_vector_change_enable_cnt = VBMC_WIN_CYC;
				next_blk_seq = 1'b1;
			end else if (ctrl[VBMC_BIT_VECTOR_CHANGE_ENABLE]) begin
				next_ctrl[VBMC_BIT_VECTOR_BASE_SELECT] = bus.wdata[VBMC_BIT_VECTOR_BASE_SELECT];
				next_ctrl[VBMC_BIT_VECTOR_CHANGE_ENABLE] = 1'b0;
				next_vector_change_enable_cnt = 3'h0;
				next_blk_tail = 1'b1;
			end
			// the second equal write inside the window commits the new value
			if (jtd_cnt != 3'h0 && bus.wdata[VBMC_BIT_JTD] == jtd_val) begin
				next_ctrl[VBMC_BIT_JTD] = jtd_val;
				next_jtd_cnt = 3'h0;
			end else if (bus.wdata[VBMC_BIT_JTD] != ctrl[VBMC_BIT_JTD]) begin
				next_jtd_val = bus.wdata[VBMC_BIT_JTD];
				next_jtd_cnt = VBMC_WIN_CYC;
			end
			if (bus.wdata[VBMC_BIT_BROWNOUT_SLEEP_OFF] && bus.wdata[VBMC_BIT_BROWNOUT_SLEEP_UNLOCK]) begin
				next_ctrl[VBMC_BIT_BROWNOUT_SLEEP_UNLOCK] = 1'b1;
				next_brownout_sleep_unlock_cnt = VBMC_WIN_CYC;
			end else if (brownout_sleep_unlock_cnt != 3'h0 && bus.wdata[VBMC_BIT_BROWNOUT_SLEEP_OFF]) begin
				next_ctrl[VBMC_BIT_BROWNOUT_SLEEP_UNLOCK] = 1'b0;
				next_ctrl[VBMC_BIT_BROWNOUT_SLEEP_OFF] = 1'b1;
				next_brownout_sleep_unlock_cnt = 3'h0;
				next_brownout_sleep_off_cnt = VBMC_BROWNOUT_SLEEP_OFF_DLY;
				next_brownout_sleep_off_act = 1'b0;
			end
		end
		next_ctrl = next_ctrl & VBMC_RMASK;
	end

	// read port: data shows the register as it stood before a write in the same cycle
	always_comb begin
		next_rvalid = bus.rd && hit;
		next_rdata = (bus.rd && hit) ? (ctrl & VBMC_RMASK) : 8'h00;
	end

	// fetch addresses
	always_comb begin
		// fuse value 0 means programmed
		next_reset_addr = fuse.boot_reset_fuse ? VBMC_APP_RESET : fuse.boot_start;
		next_vector_addr = (vector_num == 7'h0) ? next_reset_addr :
			(ctrl[VBMC_BIT_VECTOR_BASE_SELECT] ? fuse.boot_start : 16'h0000) +
			16'(vector_num) * VBMC_VEC_STRIDE;
	end

	// interrupt hold and pin-side levels
	always_comb begin
		// lock bits are active low like fuses
		lock_block = (ctrl[VBMC_BIT_VECTOR_BASE_SELECT] && !fuse.app_lock_bit && !exec_in_boot) ||
			(!ctrl[VBMC_BIT_VECTOR_BASE_SELECT] && !fuse.boot_lock_bit && exec_in_boot);
		// separate from the cpu status flag, so the global enable is never written
		next_irq_block = next_blk_seq || lock_block;
		next_debug_port_en = !next_ctrl[VBMC_BIT_JTD] && !fuse.debug_port_fuse;
		next_brownout_sleep_active = next_brownout_sleep_off_act;
		next_pullup_global_off = next_ctrl[VBMC_BIT_PUD];
	end

	// control register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= VBMC_RESET_VAL;
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// vector select unlock window and its interrupt hold
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			vector_change_enable_cnt <= 3'h0;
			blk_seq <= 1'b0;
			blk_tail <= 1'b0;
		end else begin
			vector_change_enable_cnt <= next_vector_change_enable_cnt;
			blk_seq <= next_blk_seq;
			blk_tail <= next_blk_tail;
		end
	end

	// debug-port disable double-write window
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			jtd_cnt <= 3'h0;
			jtd_val <= 1'b0;
		end else begin
			jtd_cnt <= next_jtd_cnt;
			jtd_val <= next_jtd_val;
		end
	end

	// brownout-off request: unlock window, then delay and hold counts
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			brownout_sleep_unlock_cnt <= 3'h0;
			brownout_sleep_off_cnt <= 3'h0;
			brownout_sleep_off_act <= 1'b0;
		end else begin
			brownout_sleep_unlock_cnt <= next_brownout_sleep_unlock_cnt;
			brownout_sleep_off_cnt <= next_brownout_sleep_off_cnt;
			brownout_sleep_off_act <= next_brownout_sleep_off_act;
		end
	end

	// read answer, one cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// fetch addresses are registered so the cpu sees a settled value
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reset_addr <= VBMC_APP_RESET;
			vector_addr <= VBMC_APP_RESET;
		end else begin
			reset_addr <= next_reset_addr;
			vector_addr <= next_vector_addr;
		end
	end

	// pin-side outputs other than the lock term of irq_block are registered from the next register value, so they change on the same edge as the register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_block <= 1'b0;
			debug_port_en <= 1'b0;
			brownout_sleep_active <= 1'b0;
			pullup_global_off <= 1'b0;
		end else begin
			irq_block <= next_irq_block;
			debug_port_en <= next_debug_port_en;
			brownout_sleep_active <= next_brownout_sleep_active;
			pullup_global_off <= next_pullup_global_off;
		end
	end
endmodule

// file: verif/test_vbmc_top.sv
// self-checking testbench for the vector base and mcu control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
	$display("MISMATCH %0t bad value", $time); end end
module test_vbmc_top import vbmc_pkg::*;;
	logic        mclk = 0, rstn = 0, instr_done = 0, exec_in_boot = 0, seen;
	vbmc_bus_t   bus = '0;
	vbmc_fuse_t  fuse = '1;
	logic [6:0]  vector_num = '0;
	logic [7:0]  rdata, expq[$];
	logic        rvalid, irq_block, debug_port_en, brownout_sleep_active, pullup_global_off;
	logic [15:0] reset_addr, vector_addr;
	int          bad_count = 0, n_compared = 0, seed = 32'h235d481c;
	always #2 mclk = ~mclk;
	vbmc_top vbmc_top_i (.mclk, .rstn, .bus, .fuse, .instr_done, .exec_in_boot, .vector_num,
		.rdata, .rvalid, .reset_addr, .vector_addr, .irq_block, .debug_port_en,
		.brownout_sleep_active, .pullup_global_off);
	always @(posedge mclk) begin
		instr_done <= 1'($random(seed));
		exec_in_boot <= 1'($random(seed));
	end
	// every answered read must have a note waiting for it
	always @(posedge mclk) #1 if (rvalid === 1'b1) begin
		if (expq.size() == 0) `CHK(1'b1, 1'b0)
		else `CHK(rdata, expq.pop_front())
	end
	task automatic op(input logic w, input logic [7:0] a, d);
		@(posedge mclk);
		vector_num <= 7'($random(seed));
		bus <= '{wr: w, rd: !w, io_space: a[7:6] == 2'b00, addr: a, wdata: d};
		@(posedge mclk);
		bus.wr <= 1'b0;
		bus.rd <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		expq.push_back(e);
		op(0, a, 8'h00);
	endtask
	task automatic wr(input logic [7:0] d); op(1, 8'h55, d); endtask
	task automatic wait_n(input int n); repeat (n) @(posedge mclk); endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		fuse.debug_port_fuse <= 1'b0;
		fuse.boot_start <= 16'($random(seed));
		wait_n(5);
		rstn <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			fuse.boot_reset_fuse <= i[0];
			wait_n(3);
			`CHK(reset_addr, i ? VBMC_APP_RESET : fuse.boot_start)
		end
		`CHK(debug_port_en, 1'b1)
		rd(8'h55, 8'h00);
		rd(8'h35, 8'h00);
		op(0, 8'h56, 8'h00);
		op(1, 8'h35, 8'h1e);
		rd(8'h55, 8'h10);
		$display("t1 done");
		wr(8'h11);
		wr(8'h12);
		rd(8'h35, 8'h12);
		vector_num <= 7'h05;
		wait_n(2);
		`CHK(vector_addr, fuse.boot_start + 16'h000a)
		wr(8'h13);
		wait_n(1);
		#1 `CHK(irq_block, 1'b1)
		wait_n(5);
		#1 `CHK(irq_block, 1'b0)
		wr(8'h10);
		rd(8'h55, 8'h12);
		$display("t2 done");
		wr(8'h92);
		wait_n(6);
		wr(8'h12);
		wr(8'h92);
		rd(8'h55, 8'h12);
		wr(8'h92);
		rd(8'h55, 8'h92);
		`CHK(debug_port_en, 1'b0)
		wr(8'hf2);
		wr(8'hd2);
		seen = 0;
		repeat (12) @(posedge mclk) seen |= brownout_sleep_active;
		`CHK(seen, 1'b1)
		rd(8'h55, 8'h92);
		wait_n(3);
		// vectors sit in boot and the application lock is programmed
		fuse.app_lock_bit <= 1'b0;
		wait_n(2);
		repeat (8) begin
			@(posedge mclk) seen = exec_in_boot;
			#1 `CHK(irq_block, !seen)
		end
		$display("t3 done");
		report_and_stop();
	end
	initial begin
		#20000;
		bad_count++;
		report_and_stop();
	end
endmodule

// file: verif/vbmc_assertions.sv
// concurrent checks on the ports of the vector base and mcu control block
`timescale 1ns/1ps
module vbmc_assertions import vbmc_pkg::*; (
	input wire logic        mclk,                  // cpu clock
	input wire logic        rstn,                  // async reset
	input wire vbmc_bus_t   bus,                   // register access
	input wire vbmc_fuse_t  fuse,                  // fuse levels
	input wire logic [6:0]  vector_num,            // vector index
	input wire logic [7:0]  rdata,                 // read data
	input wire logic        rvalid,                // read valid
	input wire logic [15:0] reset_addr,            // reset fetch
	input wire logic [15:0] vector_addr,           // vector address
	input wire logic        irq_block,             // interrupts held
	input wire logic        brownout_sleep_active, // brownout off
	input wire logic        pullup_global_off      // pull-ups off
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire logic hit = bus.io_space ? bus.addr == VBMC_IO_OFS : bus.addr == VBMC_DATA_OFS;
	property p_rst; 1 |=> reset_addr ==
		($past(fuse.boot_reset_fuse) ? 16'h0000 : $past(fuse.boot_start)); endproperty
	a_rst: assert property (p_rst) else $error("reset address wrong");
	property p_rd; bus.rd && hit |=> rvalid && rdata[3:2] == 2'b00; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_miss; !(bus.rd && hit) |=> !rvalid && rdata == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("unexpected read data");
	property p_pud; rvalid |-> rdata[VBMC_BIT_PUD] == pullup_global_off; endproperty
	a_pud: assert property (p_pud) else $error("pull-up output wrong");
	property p_vec0; $past(rstn) && vector_num == 7'h00 && $stable(fuse) |=>
		vector_addr == reset_addr; endproperty
	a_vec0: assert property (p_vec0) else $error("vector zero wrong");
	property p_vec; rvalid && $stable(vector_num) && $stable(fuse) && vector_num != 7'h00 |->
		vector_addr == (rdata[VBMC_BIT_VECTOR_BASE_SELECT] ? fuse.boot_start : 16'h0000)
		+ {8'h00, vector_num, 1'b0}; endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");
	property p_vector_change_enable; bus.wr && hit && bus.wdata[VBMC_BIT_VECTOR_CHANGE_ENABLE] && fuse.app_lock_bit
		&& fuse.boot_lock_bit |=> irq_block ##[1:40] !irq_block; endproperty
	a_vector_change_enable: assert property (p_vector_change_enable) else $error("unlock blocking wrong");
	property p_brownout_sleep_off; $rose(brownout_sleep_active) |->
		brownout_sleep_active [*3] ##1 !brownout_sleep_active; endproperty
	a_brownout_sleep_off: assert property (p_brownout_sleep_off) else $error("brownout pulse wrong");
endmodule
bind vbmc_top vbmc_assertions vbmc_assertions_i (.mclk, .rstn, .bus, .fuse, .vector_num,
	.rdata, .rvalid, .reset_addr, .vector_addr, .irq_block, .brownout_sleep_active,
	.pullup_global_off);
